// ### rtl/slru_pkg.sv
// Package: constants for the semaphore lock request unit
package slru_pkg;
   localparam int          SLRU_ADDR_W        = 14;           // Semaphore index width (16K entries)
   localparam int          SLRU_ENTRY_W       = 8;            // One lock entry is one byte
   localparam int          SLRU_HALFWORDS_BLK = 32;           // Shared-memory halfwords guarded per entry
   localparam int          SLRU_HALFWORD_W    = 16;           // Shared-memory halfword width
   // Request control word bit positions
   localparam int          SLRU_CTL_LOCK      = 0;
   localparam int          SLRU_CTL_UNLOCK    = 1;
   localparam int          SLRU_CTL_RNW       = 2;
   localparam int          SLRU_CTL_MEMREQ    = 3;
   localparam int          SLRU_CTL_SLOT_LO   = 4;
   // Status word bit positions
   localparam int          SLRU_ST_CRC_ERR    = 5;
   localparam int          SLRU_ST_COMPLETE   = 4;
   // Entry field positions
   localparam int          SLRU_ENT_HELD      = 0;
   localparam int          SLRU_ENT_SLOT_LO   = 4;
   localparam logic [7:0]  SLRU_ENTRY_FREE    = 8'h00;        // Value of every entry after reset
   localparam logic [7:0]  SLRU_CTL_MASK      = 8'hFF;
   // Engine states, one-hot
   typedef enum logic [3:0]
   {
      SLRU_IDLE  = 4'h1,
      SLRU_READ  = 4'h2,
      SLRU_WRITE = 4'h4,
      SLRU_CLEAR = 4'h8
   } slru_state_t;
endpackage

// ### rtl/slru_core.sv
// Semaphore lock request unit: per-link request hold, round-robin arbiter, lock store
`timescale 1ns/1ps
module slru_core
   import slru_pkg::*;
#(
   parameter int N_LINKS = 4                                  // Number of adapter links
)
(
   input  wire logic                          clk,
   input  wire logic                          rst_b,
   input  wire logic [N_LINKS-1:0]            req_valid,      // Request packet arrived (pulse)
   input  wire logic [N_LINKS*8-1:0]          req_control,    // Control byte per link
   input  wire logic [N_LINKS*14-1:0]         req_addr,       // Semaphore address per link
   input  wire logic [N_LINKS*8-1:0]          req_data,       // Unlock data per link
   input  wire logic [N_LINKS-1:0]            crc_done,       // CRC check finished (pulse)
   input  wire logic [N_LINKS-1:0]            crc_ok,         // CRC result, valid with crc_done
   output logic [N_LINKS-1:0]                 status_valid,   // One-cycle status strobe per link
   output logic [N_LINKS*8-1:0]               status_word,    // Status byte per link
   output logic [N_LINKS*8-1:0]               status_data,    // Lock acquired flag per link, 8'h01 or 8'h00
   output logic                               init_done       // Store cleared, ready to serve
);
   import slru_pkg::*;

   // Each entry guards a fixed run of SLRU_HALFWORDS_BLK shared halfwords; the mapping is linear
   localparam int DEPTH = 1 << SLRU_ADDR_W;                   // 16K entries

   // Lock store, flip-flops addressed by index
   logic [7:0]                  store_reg [DEPTH];
   // Per-link holding slot for one request
   logic [N_LINKS-1:0]          held_reg;                     // Request captured, CRC pending
   logic [N_LINKS-1:0]          ready_reg;                    // CRC passed, waiting for arbiter
   logic [N_LINKS*8-1:0]        ctl_reg;
   logic [N_LINKS*14-1:0]       adr_reg;
   logic [N_LINKS*8-1:0]        dat_reg;
   // Engine
   slru_state_t                 state_reg;
   logic [$clog2(N_LINKS)-1:0]  grant_reg;                    // Link being served
   logic [$clog2(N_LINKS)-1:0]  last_reg;                     // Last served, for round robin
   logic [SLRU_ADDR_W-1:0]      clr_reg;                      // Clear sweep index
   logic [7:0]                  rd_reg;                       // Entry read in RMW
   logic [N_LINKS-1:0]          grant_done;                   // Engine finished this link
   logic [N_LINKS-1:0]          crc_fail_stat;                // CRC error status this cycle
   logic                        pick_ok;
   logic [$clog2(N_LINKS)-1:0]  pick;

   // Round-robin search starting after the last served link
   always_comb
   begin
      pick_ok = 1'b0;
      pick    = last_reg;
      for (int k = 1; k <= N_LINKS; k++)
      begin
         if (!pick_ok && ready_reg[(int'(last_reg) + k) % N_LINKS])
         begin
            pick_ok = 1'b1;                                   // Fair rotating priority
            pick    = $clog2(N_LINKS)'((int'(last_reg) + k) % N_LINKS);
         end
      end
   end

   // Per-link capture and CRC hold; the buffer is a single packet since the
   // interlocked handshake allows only one outstanding request per link
   genvar g;
   generate
      for (g = 0; g < N_LINKS; g++)
      begin : g_link
         always_ff @(posedge clk or negedge rst_b)
         begin
            if (!rst_b)
            begin
               held_reg[g]       <= 1'b0;
               ready_reg[g]      <= 1'b0;
               ctl_reg[g*8+:8]   <= 8'h00;
               adr_reg[g*14+:14] <= 14'h0000;
               dat_reg[g*8+:8]   <= 8'h00;
               crc_fail_stat[g]  <= 1'b0;
            end
            else
            begin
               crc_fail_stat[g] <= 1'b0;
               if (req_valid[g] && !held_reg[g] && !ready_reg[g])
               begin
                  held_reg[g]       <= 1'b1;                  // Hold until CRC finished
                  ctl_reg[g*8+:8]   <= req_control[g*8+:8] & SLRU_CTL_MASK;
                  adr_reg[g*14+:14] <= req_addr[g*14+:14];    // Low 14 bits only
                  dat_reg[g*8+:8]   <= req_data[g*8+:8];      // Low 8 bits only
               end
               else if (held_reg[g] && crc_done[g])
               begin
                  held_reg[g] <= 1'b0;
                  if (crc_ok[g])
                     ready_reg[g] <= 1'b1;                    // Queue for the arbiter
                  else
                     crc_fail_stat[g] <= 1'b1;                // No access, report error
               end
               else if (grant_done[g])
               begin
                  ready_reg[g] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // Engine: clear sweep after reset, then one RMW per grant
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_reg <= SLRU_CLEAR;
         clr_reg   <= '0;
         grant_reg <= '0;
         last_reg  <= $clog2(N_LINKS)'(N_LINKS - 1);
         rd_reg    <= 8'h00;
         init_done <= 1'b0;
      end
      else
      begin
         case (state_reg)
            SLRU_CLEAR:
            begin
               clr_reg <= clr_reg + SLRU_ADDR_W'(1);          // Sweep every entry to free
               if (clr_reg == SLRU_ADDR_W'(DEPTH - 1))
               begin
                  state_reg <= SLRU_IDLE;
                  init_done <= 1'b1;
               end
            end
            SLRU_IDLE:
            begin
               if (pick_ok)
               begin
                  grant_reg <= pick;                          // Arbiter picks one link
                  state_reg <= SLRU_READ;
               end
            end
            SLRU_READ:
            begin
               rd_reg    <= store_reg[adr_reg[grant_reg*14+:14]];
               state_reg <= SLRU_WRITE;                       // No grant change mid-RMW
            end
            SLRU_WRITE:
            begin
               last_reg  <= grant_reg;
               state_reg <= SLRU_IDLE;
            end
            default:
               state_reg <= SLRU_IDLE;
         endcase
      end
   end

   always_comb
   begin
      grant_done = '0;
      if (state_reg == SLRU_WRITE)
         grant_done[grant_reg] = 1'b1;
   end

   // Store writes: clear sweep, lock RMW, or direct unlock write
   always_ff @(posedge clk)
   begin
      if (state_reg == SLRU_CLEAR)
         store_reg[clr_reg] <= SLRU_ENTRY_FREE;
      else if (state_reg == SLRU_WRITE)
      begin
         if (ctl_reg[grant_reg*8 + SLRU_CTL_UNLOCK])
            store_reg[adr_reg[grant_reg*14+:14]] <= dat_reg[grant_reg*8+:8];
         else if (ctl_reg[grant_reg*8 + SLRU_CTL_LOCK] && !rd_reg[SLRU_ENT_HELD])
            store_reg[adr_reg[grant_reg*14+:14]] <=
               {ctl_reg[grant_reg*8 + SLRU_CTL_SLOT_LO +: 4], 3'b000, 1'b1};
      end
   end

   // Status return: exactly one packet per request
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         status_valid <= '0;
         status_word  <= '0;
         status_data  <= '0;
      end
      else
      begin
         status_valid <= crc_fail_stat | grant_done;
         for (int i = 0; i < N_LINKS; i++)
         begin
            if (crc_fail_stat[i])
            begin
               status_word[i*8+:8] <= 8'h00;
               status_word[i*8 + SLRU_ST_CRC_ERR] <= 1'b1;
               status_data[i*8+:8] <= 8'h00;
            end
            else if (grant_done[i])
            begin
               status_word[i*8+:8] <= ctl_reg[i*8+:8] & 8'h0F; // Echo request bits
               status_word[i*8 + SLRU_ST_COMPLETE] <= 1'b1;
               // Held flag reported only to the acquirer
               // Unlock wins over lock when both bits are set, so that case never acquires
               status_data[i*8+:8] <= (ctl_reg[i*8 + SLRU_CTL_LOCK] && !ctl_reg[i*8 + SLRU_CTL_UNLOCK]
                                       && !rd_reg[SLRU_ENT_HELD]) ? 8'h01 : 8'h00;
            end
         end
      end
   end

   // Assertions
   chk_one_status: assert property (@(posedge clk) disable iff (!rst_b)
      grant_done[grant_reg] |=> status_valid[grant_reg])
      else $error("grant without status");
   chk_crc_noacc: assert property (@(posedge clk) disable iff (!rst_b)
      crc_fail_stat[0] |=> (status_valid[0] && status_word[SLRU_ST_CRC_ERR]
                            && !status_word[SLRU_ST_COMPLETE] && !ready_reg[0]))
      else $error("crc status missing");
   chk_rmw_seq: assert property (@(posedge clk) disable iff (!rst_b)
      (state_reg == SLRU_READ) |=> (state_reg == SLRU_WRITE) ##1 (state_reg == SLRU_IDLE))
      else $error("rmw interrupted");
   chk_grant_stable: assert property (@(posedge clk) disable iff (!rst_b)
      (state_reg == SLRU_READ) |=> $stable(grant_reg))
      else $error("grant moved mid rmw");
   chk_init_first: assert property (@(posedge clk) disable iff (!rst_b)
      !init_done |-> (status_valid == '0 || $past(crc_fail_stat) != '0))
      else $error("served before init");
   chk_ack_once: assert property (@(posedge clk) disable iff (!rst_b)
      status_valid[0] |=> !status_valid[0])
      else $error("double status");
   chk_held_lock: assert property (@(posedge clk) disable iff (!rst_b)
      (grant_done[grant_reg] && rd_reg[SLRU_ENT_HELD]) |=> status_data[grant_reg*8+:8] == 8'h00)
      else $error("busy lock reported granted");
   chk_wait_crc: assert property (@(posedge clk) disable iff (!rst_b)
      held_reg[0] && !crc_done[0] |=> !ready_reg[0] || $past(ready_reg[0]))
      else $error("acted before crc");
   cov_lock_grant: cover property (@(posedge clk) status_valid[0] && status_data[0]);
   cov_crc_fail:   cover property (@(posedge clk) status_valid[0] && status_word[SLRU_ST_CRC_ERR]);
   cov_contend:    cover property (@(posedge clk) $countones(ready_reg) > 1);
endmodule

// ### verif/slru_adapter_model.sv
// Adapter-side model of one link: one request, then its CRC verdict
`timescale 1ns/1ps
module slru_adapter_model (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        go,          // Start one request
   input  wire logic [7:0]  ctl,         // Control byte to send
   input  wire logic [13:0] addr,        // Semaphore index to send
   input  wire logic [7:0]  data,        // Unlock data to send
   input  wire logic        good,        // CRC verdict to present
   output logic             req_valid,
   output logic [7:0]       req_control,
   output logic [13:0]      req_addr,
   output logic [7:0]       req_data,
   output logic             crc_done,
   output logic             crc_ok
);
   // Request pulse, verdict one cycle later; released lines never hold
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         {req_valid, crc_done, crc_ok} <= 3'h0;
         {req_control, req_addr, req_data} <= '0;
      end
      else if (go)
      begin
         req_valid <= 1'b1;
         req_control <= ctl;
         req_addr <= addr;
         req_data <= data;
      end
      else
      begin
         req_valid <= 1'b0;
         crc_done <= req_valid;
         // Verdict only meaningful with crc_done, so scramble it otherwise
         crc_ok <= req_valid ? good : ~crc_ok;
         // Toggle released fields so a late capture is caught
         if (!req_valid)
            {req_control, req_addr, req_data} <= ~{req_control, req_addr, req_data};
      end
   end
endmodule

// ### verif/tb.sv
// Self-checking bench for the semaphore lock request unit
`timescale 1ns/1ps
module tb;
   import slru_pkg::*;
   localparam int N = 4;
   logic clk, rst_b, init_done;
   logic [N-1:0] go, good, req_valid, crc_done, crc_ok, status_valid;
   logic [N*8-1:0] req_control, req_data, status_word, status_data;
   logic [N*14-1:0] req_addr;
   logic [7:0] ctl [N];
   logic [13:0] adr [N];
   logic [7:0] dat [N];
   logic [7:0] ent [int];              // Expected store contents
   int errors, check_count, seed, cyc;
   int st_cnt [N];
   int rq_cnt [N];

   for (genvar i = 0; i < N; i++)
   begin : g_link
      slru_adapter_model slru_adapter_model_i (.clk(clk), .rst_b(rst_b), .go(go[i]), .ctl(ctl[i]),
         .addr(adr[i]), .data(dat[i]), .good(good[i]), .req_valid(req_valid[i]),
         .req_control(req_control[i*8+:8]), .req_addr(req_addr[i*14+:14]), .req_data(req_data[i*8+:8]),
         .crc_done(crc_done[i]), .crc_ok(crc_ok[i]));
   end

   slru_core #(.N_LINKS(N)) slru_core_i (.clk(clk), .rst_b(rst_b), .req_valid(req_valid),
      .req_control(req_control), .req_addr(req_addr), .req_data(req_data), .crc_done(crc_done),
      .crc_ok(crc_ok), .status_valid(status_valid), .status_word(status_word),
      .status_data(status_data), .init_done(init_done));

   // 100 ns clock
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Status strobes per link, and a hang guard
   always @(posedge clk)
   begin
      cyc++;
      for (int i = 0; i < N; i++)
         st_cnt[i] += (rst_b && status_valid[i] === 1'b1);
      if (cyc == 40000)
      begin
         errors++;
         $display("CHECK FAILED t=%0t timeout", $time);
         finish_test();
      end
   end

   task automatic finish_test();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // Expected entry data; unlock writes verbatim, lock only when free
   function automatic logic [7:0] model(input logic [7:0] c, input int a, input logic [7:0] d);
      logic [7:0] e;
      e = ent.exists(a) ? ent[a] : SLRU_ENTRY_FREE;
      if (c[SLRU_CTL_UNLOCK])
      begin
         ent[a] = d;
         return 8'h00;
      end
      if (e[SLRU_ENT_HELD])
         return 8'h00;
      ent[a] = {c[7:4], 3'h0, 1'b1};
      return 8'h01;
   endfunction

   // One interlocked request; waits for its single status strobe
   task automatic xact(input int l, input logic [7:0] c, input logic [13:0] a, input logic [7:0] d,
                       input logic g, output logic [7:0] w, output logic [7:0] r);
      int k;
      @(posedge clk);
      ctl[l] <= c;
      adr[l] <= a;
      dat[l] <= d;
      good[l] <= g;
      go[l] <= 1'b1;
      @(posedge clk);
      go[l] <= 1'b0;
      rq_cnt[l]++;
      for (k = 0; k < 200 && status_valid[l] !== 1'b1; k++)
         @(negedge clk);
      chk(8'(status_valid[l]), 8'h01, "status strobe");
      w = status_word[l*8+:8];
      r = status_data[l*8+:8];
   endtask

   task automatic op(input int l, input logic [7:0] c, input logic [13:0] a, input logic [7:0] d, input logic g);
      logic [7:0] w, r;
      xact(l, c, a, d, g, w, r);
      chk(w, g ? {4'h1, c[3:0]} : 8'(1 << SLRU_ST_CRC_ERR), "status word");
      chk(r, g ? model(c, a, d) : 8'h00, "status data");
   endtask

   initial
   begin
      logic [7:0] r [N];
      logic [7:0] w [N];
      logic [7:0] c, d;
      logic [13:0] a;
      int l, k;
      seed = 32'h8E71C59D;
      rst_b = 1'b0;
      {go, good} = '0;
      ctl = '{default: 8'h00};
      adr = '{default: 14'h0};
      dat = '{default: 8'h00};
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      op(0, 8'h11, 14'h3FFF, 8'h00, 1'b0);
      chk(8'(init_done), 8'h00, "early ready");
      for (k = 0; k < 17000 && init_done !== 1'b1; k++)
         @(negedge clk);
      chk(8'(init_done), 8'h01, "ready");
      op(0, 8'h11, 14'h3FFF, 8'h00, 1'b1);
      op(1, 8'h21, 14'h0000, 8'h00, 1'b1);
      op(1, 8'h21, 14'h3FFF, 8'h00, 1'b1);
      op(0, 8'h12, 14'h3FFF, 8'h01, 1'b1);
      op(2, 8'h31, 14'h3FFF, 8'h00, 1'b1);
      op(0, 8'h12, 14'h3FFF, 8'h00, 1'b1);
      op(2, 8'h31, 14'h3FFF, 8'h00, 1'b0);
      op(3, 8'h41, 14'h3FFF, 8'h00, 1'b1);
      op(2, 8'h31, 14'h3FFF, 8'h00, 1'b1);
      // All links race for one entry; only one may win
      fork
         xact(0, 8'h11, 14'h0100, 8'h00, 1'b1, w[0], r[0]);
         xact(1, 8'h21, 14'h0100, 8'h00, 1'b1, w[1], r[1]);
         xact(2, 8'h31, 14'h0100, 8'h00, 1'b1, w[2], r[2]);
         xact(3, 8'h41, 14'h0100, 8'h00, 1'b1, w[3], r[3]);
      join
      chk(r[0] + r[1] + r[2] + r[3], 8'h01, "race winners");
      repeat (150)
      begin
         l = $unsigned($random(seed)) % N;
         a = 14'h0010 + 14'($unsigned($random(seed)) % 4);
         d = 8'($random(seed));
         c = {4'(l + 1), 2'b00, ($random(seed) & 1) ? 2'b10 : 2'b01};
         op(l, c, a, d, ($random(seed) % 8) != 0);
      end
      // Let the strobe counter see the last status before comparing
      repeat (2) @(negedge clk);
      for (k = 0; k < N; k++)
         chk(8'(st_cnt[k]), 8'(rq_cnt[k]), "status count");
      finish_test();
   end
endmodule
